// ### hw/tcu_pkg.sv
// constants shared by the timer-two control unit and its testbench
// How it works
// [R01] The high overflow flag sets whenever the high byte wraps from FF to 00.
// [R02] In 16-bit mode the high flag sets when FFFF wraps to 0000, and on a capture.
// [R03] With the timer interrupt enabled, a set high flag requests an irq.
// [R04] Both overflow flags stay set until software writes them to zero.
// [R05] The low flag sets on every low byte wrap from FF to 00, in any mode.
// [R06] With low irq enable and timer irq enable, low wraps also request.
// [R07] Capture enable at one selects capture mode, at zero leaves it.
// [R08] Split select at one gives two 8-bit reload timers, else one 16-bit.
// [R09] Run control starts and stops the timer; in split only the high byte.
// [R10] Aux select picks count clock: 00/10 clk/12, 01 comp, 11 rtc/8.
// [R11] Aux select picks capture trigger: 00/01 rtc/8, 10/11 comparator.
// [R12] In split both bytes share the aux clock; each may pick system clock.
// [R13] Every auxiliary source is synchronised before count or capture use.
// [R14] Control sits at C8, is bit writable and resets to all zeros.
// [R15] A wrap reloads the counter, except a 16-bit wrap with capture on; in split each byte from its own reload.
// [R16] A capture trigger copies the counter into reload and sets high flag.
// [R17] A running byte steps once per selected tick; writes override it.
package tcu_pkg;
    // register byte addresses
    localparam logic [7:0] TCU_ADDR_CTL = 8'hC8;
    localparam logic [7:0] TCU_ADDR_RLL = 8'hCA;
    localparam logic [7:0] TCU_ADDR_RLH = 8'hCB;
    localparam logic [7:0] TCU_ADDR_CNL = 8'hCC;
    localparam logic [7:0] TCU_ADDR_CNH = 8'hCD;
    localparam logic [7:0] TCU_ADDR_CKS = 8'hCE;
    localparam logic [7:0] TCU_ADDR_STAT = 8'hC4;
    localparam logic [7:0] TCU_ADDR_MASK = 8'hC5;
    // control register fields
    localparam int TCU_CTL_HOF = 7;
    localparam int TCU_CTL_LOF = 6;
    localparam int TCU_CTL_LIE = 5;
    localparam int TCU_CTL_CAP = 4;
    localparam int TCU_CTL_SPLIT = 3;
    localparam int TCU_CTL_RUN = 2;
    localparam int TCU_CTL_AUX = 0;
    // clock select register fields
    localparam int TCU_CKS_LOW = 0;
    localparam int TCU_CKS_HIGH = 1;
    // status and mask fields
    localparam int TCU_EV_HIGH = 0;
    localparam int TCU_EV_LOW = 1;
    localparam int TCU_EV_CAP = 2;
    // reset values
    localparam logic [7:0] TCU_RST_BYTE = 8'h00;
    localparam logic [2:0] TCU_RST_EV = 3'h0;
    // aux select codes
    localparam logic [1:0] TCU_AUX_DIV12 = 2'h0;
    localparam logic [1:0] TCU_AUX_CMP = 2'h1;
    localparam logic [1:0] TCU_AUX_DIV12B = 2'h2;
    localparam logic [1:0] TCU_AUX_RTC = 2'h3;
    // timing counts
    localparam logic [3:0] TCU_DIV12_LAST = 4'hB;
    localparam logic [2:0] TCU_RTC8_LAST = 3'h7;
    localparam logic [7:0] TCU_BYTE_TOP = 8'hFF;
endpackage

// ### hw/tcu_sync.sv
// three-stage synchroniser with a rising edge pulse for one async input
`timescale 1ns/1ns
module tcu_sync
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic asyncIn,
    output logic rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    wire agree = (s2_r == s3_r);
    wire levelNxt = agree ? s3_r : level_r;

    // first stage feeds only the second; level moves once 2 and 3 agree
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            s1_r <= asyncIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= levelNxt;
            rise <= levelNxt & ~level_r;
        end
    end
endmodule

// ### hw/tcu_timer2.sv
// timer-two counter, reload, capture, control register and interrupt
`timescale 1ns/1ns
module tcu_timer2
    import tcu_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic bitWr,
    input wire logic [2:0] bitSel,
    input wire logic bitVal,
    input wire logic cmpIn,
    input wire logic rtcIn,
    output logic irq
);
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic [7:0] cntLo_r;
    logic [7:0] cntLo_nxt;
    logic [7:0] cntHi_r;
    logic [7:0] cntHi_nxt;
    logic [7:0] relLo_r;
    logic [7:0] relLo_nxt;
    logic [7:0] relHi_r;
    logic [7:0] relHi_nxt;
    logic [1:0] cks_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic [3:0] div12_r;
    logic [2:0] rtc8_r;
    logic setHigh;
    logic setLow;
    logic capHit;
    logic cmpRise;
    logic rtcRise;

    // slow sources cross into the system clock here
    tcu_sync uCmpSync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(cmpIn),
        .rise(cmpRise)
    );
    tcu_sync uRtcSync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(rtcIn),
        .rise(rtcRise)
    );

    // control fields
    wire highFlag = ctl_r[TCU_CTL_HOF];
    wire lowFlag = ctl_r[TCU_CTL_LOF];
    wire lowIrqEn = ctl_r[TCU_CTL_LIE];
    wire capEn = ctl_r[TCU_CTL_CAP];
    wire split = ctl_r[TCU_CTL_SPLIT];
    wire run = ctl_r[TCU_CTL_RUN];
    wire [1:0] auxSel = ctl_r[TCU_CTL_AUX +: 2];
    wire timerIrqEn = mask_r[TCU_EV_HIGH];

    // tick sources, all single cycle pulses on clk
    wire div12Tick = (div12_r == TCU_DIV12_LAST);
    wire rtc8Tick = rtcRise & (rtc8_r == TCU_RTC8_LAST); // [R13]
    wire cmpTick = cmpRise; // [R13]

    // aux clock mux; both reserved-looking codes give clk/12
    wire auxTick = (auxSel == TCU_AUX_CMP) ? cmpTick : // [R10]
                   (auxSel == TCU_AUX_RTC) ? rtc8Tick :
                   div12Tick;
    // capture trigger follows the upper select bit only
    wire capTick = auxSel[1] ? cmpTick : rtc8Tick; // [R11]

    // each byte picks undivided clock or the shared aux tick
    wire lowTick = cks_r[TCU_CKS_LOW] | auxTick; // [R12]
    wire highTick = cks_r[TCU_CKS_HIGH] | auxTick; // [R12]

    // address decode
    wire wrCtl = regWr & (regAddr == TCU_ADDR_CTL);
    wire wrRll = regWr & (regAddr == TCU_ADDR_RLL);
    wire wrRlh = regWr & (regAddr == TCU_ADDR_RLH);
    wire wrCnl = regWr & (regAddr == TCU_ADDR_CNL);
    wire wrCnh = regWr & (regAddr == TCU_ADDR_CNH);
    wire wrCks = regWr & (regAddr == TCU_ADDR_CKS);
    wire wrStat = regWr & (regAddr == TCU_ADDR_STAT);
    wire wrMask = regWr & (regAddr == TCU_ADDR_MASK);

    // single bit write into the control register
    wire [7:0] bitMask = 8'h01 << bitSel;
    wire [7:0] bitData = {7'h00, bitVal} << bitSel;
    wire [7:0] ctlSw = wrCtl ? regWdata :
                       bitWr ? ((ctl_r & ~bitMask) | bitData) :
                       ctl_r; // [R14]

    // read mux, unmapped addresses answer zero
    wire [7:0] rdMux =
        (regAddr == TCU_ADDR_CTL) ? ctl_r :
        (regAddr == TCU_ADDR_RLL) ? relLo_r :
        (regAddr == TCU_ADDR_RLH) ? relHi_r :
        (regAddr == TCU_ADDR_CNL) ? cntLo_r :
        (regAddr == TCU_ADDR_CNH) ? cntHi_r :
        (regAddr == TCU_ADDR_CKS) ? {6'h00, cks_r} :
        (regAddr == TCU_ADDR_STAT) ? {5'h00, stat_r} :
        (regAddr == TCU_ADDR_MASK) ? {5'h00, mask_r} :
        TCU_RST_BYTE;

    // counting steps
    wire lowStep = split ? lowTick : (run & lowTick); // [R09]
    wire highStep = split & run & highTick; // [R09]
    wire lowWrap = lowStep & (cntLo_r == TCU_BYTE_TOP);
    wire fullWrap = ~split & lowWrap & (cntHi_r == TCU_BYTE_TOP);
    wire highWrapS = highStep & (cntHi_r == TCU_BYTE_TOP);

    // counter, reload and capture next values
    always_comb
    begin
        cntLo_nxt = cntLo_r;
        cntHi_nxt = cntHi_r;
        relLo_nxt = relLo_r;
        relHi_nxt = relHi_r;
        setHigh = 1'b0;
        setLow = 1'b0;
        capHit = capEn & capTick; // [R07]
        if (split) // [R08]
        begin
            // two independent 8-bit reload timers
            if (lowStep)
            begin
                cntLo_nxt = lowWrap ? relLo_r : cntLo_r + 8'h01; // [R15]
            end
            if (highStep)
            begin
                cntHi_nxt = highWrapS ? relHi_r : cntHi_r + 8'h01; // [R15]
            end
            setLow = lowWrap; // [R05]
            setHigh = highWrapS; // [R01]
        end
        else if (lowStep)
        begin
            // one 16-bit timer; capture mode wraps freely to keep the copy
            cntLo_nxt = cntLo_r + 8'h01; // [R17]
            if (lowWrap)
            begin
                cntHi_nxt = cntHi_r + 8'h01;
            end
            if (fullWrap & ~capEn)
            begin
                cntLo_nxt = relLo_r; // [R15]
                cntHi_nxt = relHi_r;
            end
            setLow = lowWrap; // [R05]
            setHigh = fullWrap; // [R02]
        end
        if (capHit)
        begin
            relLo_nxt = cntLo_r; // [R16]
            relHi_nxt = cntHi_r;
            setHigh = 1'b1; // [R16]
        end
        // software writes override hardware
        if (wrRll)
        begin
            relLo_nxt = regWdata;
        end
        if (wrRlh)
        begin
            relHi_nxt = regWdata;
        end
        if (wrCnl)
        begin
            cntLo_nxt = regWdata; // [R17]
        end
        if (wrCnh)
        begin
            cntHi_nxt = regWdata; // [R17]
        end
    end

    // flags: a set in the clearing cycle wins
    assign ctl_nxt = ctlSw | (8'({setHigh, setLow}) << TCU_CTL_LOF); // [R04]

    wire [2:0] events = {capHit, setLow, setHigh};
    wire [2:0] statClr = wrStat ? regWdata[2:0] : TCU_RST_EV;
    wire [2:0] statNxt = (stat_r & ~statClr) | events;

    // level request; flags stay until software clears them
    wire irqNxt = (timerIrqEn & (highFlag | (lowIrqEn & lowFlag))) // [R03]
                  | (|(stat_r & mask_r)); // [R06]

    // prescalers run off the system clock
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div12_r <= 4'h0;
            rtc8_r <= 3'h0;
        end
        else
        begin
            div12_r <= div12Tick ? 4'h0 : div12_r + 4'h1; // [R10]
            rtc8_r <= rtcRise ? rtc8_r + 3'h1 : rtc8_r; // [R13]
        end
    end

    // register file
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctl_r <= TCU_RST_BYTE; // [R14]
            cntLo_r <= TCU_RST_BYTE;
            cntHi_r <= TCU_RST_BYTE;
            relLo_r <= TCU_RST_BYTE;
            relHi_r <= TCU_RST_BYTE;
            cks_r <= 2'h0;
            stat_r <= TCU_RST_EV;
            mask_r <= TCU_RST_EV;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            cntLo_r <= cntLo_nxt;
            cntHi_r <= cntHi_nxt;
            relLo_r <= relLo_nxt;
            relHi_r <= relHi_nxt;
            cks_r <= wrCks ? regWdata[1:0] : cks_r;
            stat_r <= statNxt;
            mask_r <= wrMask ? regWdata[2:0] : mask_r;
        end
    end

    // bus answer and interrupt, both straight from flops
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            regRdata <= TCU_RST_BYTE;
            irq <= 1'b0;
        end
        else
        begin
            regRdata <= regRd ? rdMux : TCU_RST_BYTE;
            irq <= irqNxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_full_wrap_flag: assert property ( // [R02]
        fullWrap |=> ctl_r[TCU_CTL_HOF])
        else $error("16-bit wrap did not set high flag");

    a_split_high_flag: assert property ( // [R01]
        highWrapS |=> ctl_r[TCU_CTL_HOF] && cntHi_r == $past(relHi_r)
            || $past(wrCnh))
        else $error("split high wrap missed flag or reload");

    a_low_wrap_flag: assert property ( // [R05]
        lowWrap |=> ctl_r[TCU_CTL_LOF])
        else $error("low byte wrap did not set low flag");

    a_flag_sticky: assert property ( // [R04]
        highFlag && !wrCtl && !(bitWr && bitSel == 3'h7) |=> highFlag)
        else $error("high flag dropped without software clear");

    a_reload_load: assert property ( // [R15]
        fullWrap && !capEn && !wrCnl && !wrCnh
            |=> {cntHi_r, cntLo_r} == $past({relHi_r, relLo_r}))
        else $error("16-bit wrap did not reload counter");

    a_capture_copy: assert property ( // [R16]
        capHit && !wrRll && !wrRlh
            |=> {relHi_r, relLo_r} == $past({cntHi_r, cntLo_r})
            && highFlag)
        else $error("capture did not copy counter");

    a_stop_holds: assert property ( // [R09]
        !run && !split && !wrCnl && !wrCnh |=> $stable(cntLo_r)
            && $stable(cntHi_r))
        else $error("stopped 16-bit timer moved");

    a_split_low_free: assert property ( // [R09]
        split && !run && cks_r[TCU_CKS_LOW] && !wrCnl
            |=> cntLo_r != $past(cntLo_r))
        else $error("split low byte did not free run");

    a_irq_request: assert property ( // [R03]
        timerIrqEn && highFlag |=> irq)
        else $error("enabled high flag raised no interrupt");

    a_low_irq_gate: assert property ( // [R06]
        !lowIrqEn && !highFlag && stat_r == 3'h0 |=> !irq)
        else $error("low flag raised irq while disabled");

    a_div12_period: assert property ( // [R10]
        div12Tick |=> !div12Tick [*8] ##0 1'b1 ##4 div12Tick)
        else $error("clk/12 tick period wrong");

    a_read_answer: assert property ( // [R14]
        regRd && regAddr == TCU_ADDR_CTL |=> regRdata == $past(ctl_r))
        else $error("control read data wrong");
endmodule

// ### sim/timer2_control_unit_tb_top.sv
// self-checking bench for the timer-two control unit
`timescale 1ns/1ns
module timer2_control_unit_tb_top import tcu_pkg::*;;
    logic clk, sysRst, regWr, regRd, bitWr, bitVal, cmpIn, rtcIn, irq;
    logic [7:0] regAddr, regWdata, regRdata, v;
    logic [2:0] bitSel;
    logic [1:0] aux;
    int badCount, numChecks, cycles, seed, k, c;
    logic [7:0] regs [9];

    // free-running system clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    tcu_timer2 dut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .bitWr(bitWr), .bitSel(bitSel),
        .bitVal(bitVal), .cmpIn(cmpIn), .rtcIn(rtcIn), .irq(irq));

    task automatic conclude;
        if (badCount == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard, more than ten times the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            badCount++;
            $display("mismatch at %0t: run too long", $time);
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // tick counts on a divided clock depend on divider phase
    task automatic chkRange(input logic [7:0] got, input logic [7:0] lo,
        input logic [7:0] hi);
        numChecks++;
        if (!(got >= lo && got <= hi) || $isunknown(got))
        begin
            badCount++;
            $display("mismatch at %0t: %h not in %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // read data only stands in the cycle after the strobe
    task automatic rdv(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rdv(a, d);
        chk(d, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // slow square wave on the comparator or rtc input
    task automatic pulseIn(input bit useRtc, input int n, input int half);
        repeat (n)
        begin
            @(posedge clk);
            if (useRtc) rtcIn <= 1'b1;
            else cmpIn <= 1'b1;
            idle(half);
            if (useRtc) rtcIn <= 1'b0;
            else cmpIn <= 1'b0;
            idle(half);
        end
    endtask

    function automatic logic [7:0] ctlVal(input logic cap, input logic split,
        input logic run, input logic [1:0] a);
        logic [7:0] r;
        r = TCU_RST_BYTE;
        r[TCU_CTL_CAP] = cap;
        r[TCU_CTL_SPLIT] = split;
        r[TCU_CTL_RUN] = run;
        r[TCU_CTL_AUX +: 2] = a;
        return r;
    endfunction

    // main sequence
    initial
    begin
        {sysRst, regWr, regRd, bitWr, bitVal, cmpIn, rtcIn} = 7'h40;
        {regAddr, regWdata, bitSel} = 19'h0;
        seed = 32'h334D;
        regs = '{TCU_ADDR_CTL, TCU_ADDR_RLL, TCU_ADDR_RLH, TCU_ADDR_CNL,
            TCU_ADDR_CNH, TCU_ADDR_CKS, TCU_ADDR_STAT, TCU_ADDR_MASK, 8'hC9};
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        foreach (regs[i]) rdc(regs[i], 8'h00);
        wr(8'hC9, 8'hFF);
        rdc(8'hC9, 8'h00);
        repeat (6)
        begin
            v = $random(seed);
            wr(TCU_ADDR_CTL, v);
            rdc(TCU_ADDR_CTL, v);
        end
        wr(TCU_ADDR_CTL, 8'h00);
        // 16-bit wrap with both bytes on system clock
        wr(TCU_ADDR_CKS, 8'h03);
        wr(TCU_ADDR_RLL, 8'h34);
        wr(TCU_ADDR_RLH, 8'h12);
        wr(TCU_ADDR_CNL, 8'hFE);
        wr(TCU_ADDR_CNH, 8'hFF);
        wr(TCU_ADDR_MASK, 8'h01);
        wr(TCU_ADDR_CTL, ctlVal(0, 0, 1, 2'h0));
        k = 0;
        while (irq !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        chk({7'h0, irq}, 8'h01);
        wr(TCU_ADDR_CTL, 8'hC0);
        rdc(TCU_ADDR_CNH, 8'h12);
        rdv(TCU_ADDR_CNL, v);
        chkRange(v, 8'h35, 8'h50);
        idle(20);
        rdc(TCU_ADDR_CTL, 8'hC0);
        chk({7'h0, irq}, 8'h01);
        // the masked status copy also holds the request, so clear both
        wr(TCU_ADDR_CTL, 8'h00);
        wr(TCU_ADDR_STAT, 8'h07);
        idle(2);
        chk({7'h0, irq}, 8'h00);
        // low wrap alone in 16-bit mode leaves the high flag clear
        wr(TCU_ADDR_CNL, 8'hFE);
        wr(TCU_ADDR_CNH, 8'h00);
        wr(TCU_ADDR_CTL, ctlVal(0, 0, 1, 2'h0));
        idle(10);
        rdc(TCU_ADDR_CTL, 8'h44);
        chk({7'h0, irq}, 8'h00);
        // split mode, run off: only the low byte moves
        wr(TCU_ADDR_CKS, 8'h01);
        wr(TCU_ADDR_RLL, 8'hF0);
        wr(TCU_ADDR_CNL, 8'hF0);
        wr(TCU_ADDR_CNH, 8'h55);
        wr(TCU_ADDR_CTL, ctlVal(0, 1, 0, 2'h0));
        idle(40);
        rdc(TCU_ADDR_CTL, 8'h48);
        chk({7'h0, irq}, 8'h00);
        rdc(TCU_ADDR_CNH, 8'h55);
        rdv(TCU_ADDR_CNL, v);
        chkRange(v, 8'hF0, 8'hFF);
        @(posedge clk);
        {bitWr, bitSel, bitVal} <= {1'b1, 3'(TCU_CTL_LIE), 1'b1};
        @(posedge clk);
        bitWr <= 1'b0;
        idle(3);
        chk({7'h0, irq}, 8'h01);
        wr(TCU_ADDR_CTL, 8'h00);
        wr(TCU_ADDR_MASK, 8'h00);
        // each aux code as count clock
        for (c = 0; c < 4; c++)
        begin
            aux = c[1:0];
            wr(TCU_ADDR_CKS, 8'h00);
            wr(TCU_ADDR_CNL, 8'h00);
            wr(TCU_ADDR_CNH, 8'h00);
            wr(TCU_ADDR_CTL, ctlVal(0, 0, 1, aux));
            k = ($random(seed) & 7) + 1;
            if (aux == TCU_AUX_CMP) pulseIn(0, k, 5);
            else if (aux == TCU_AUX_RTC) pulseIn(1, 8 * k, 3);
            else idle(12 * k);
            idle(8);
            wr(TCU_ADDR_CTL, 8'h00);
            rdv(TCU_ADDR_CNL, v);
            if (aux == TCU_AUX_CMP) chk(v, k[7:0]);
            else if (aux == TCU_AUX_RTC)
                chkRange(v, k[7:0] - 8'h01, k[7:0]);
            else chkRange(v, k[7:0], k[7:0] + 8'h01);
        end
        // capture trigger selection per aux code
        wr(TCU_ADDR_CKS, 8'h03);
        wr(TCU_ADDR_MASK, 8'h04);
        for (c = 0; c < 4; c++)
        begin
            aux = c[1:0];
            wr(TCU_ADDR_CTL, ctlVal(1, 0, 1, aux));
            pulseIn(0, 1, 5);
            idle(6);
            rdv(TCU_ADDR_CTL, v);
            chk({7'h0, v[TCU_CTL_HOF]}, {7'h0, aux[1]});
            wr(TCU_ADDR_CTL, ctlVal(1, 0, 1, aux));
            pulseIn(1, 8, 3);
            idle(6);
            rdv(TCU_ADDR_CTL, v);
            chk({7'h0, v[TCU_CTL_HOF]}, {7'h0, ~aux[1]});
        end
        chk({7'h0, irq}, 8'h01);
        rdv(TCU_ADDR_STAT, v);
        chk(v & 8'h04, 8'h04);
        wr(TCU_ADDR_STAT, 8'h04);
        wr(TCU_ADDR_CTL, 8'h00);
        idle(2);
        chk({7'h0, irq}, 8'h00);
        // capture copies a held count into reload
        wr(TCU_ADDR_CNL, 8'h40);
        wr(TCU_ADDR_CNH, 8'hA5);
        wr(TCU_ADDR_CTL, ctlVal(1, 0, 0, TCU_AUX_DIV12B));
        pulseIn(0, 1, 5);
        idle(6);
        rdc(TCU_ADDR_RLL, 8'h40);
        rdc(TCU_ADDR_RLH, 8'hA5);
        wr(TCU_ADDR_CTL, ctlVal(0, 0, 0, TCU_AUX_DIV12B));
        pulseIn(0, 1, 5);
        idle(6);
        rdc(TCU_ADDR_CTL, 8'h02);
        conclude();
    end
endmodule
